// >>> rtl/link_regs_pkg.sv
// register map, field positions and reset values of the link register slice
package link_regs_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] TX_MASK_SET_OFS    = 8'h98;
   localparam logic [7:0] TX_MASK_CLR_OFS    = 8'h9c;
   localparam logic [7:0] RX_EVENT_SET_OFS   = 8'ha0;
   localparam logic [7:0] RX_EVENT_CLR_OFS   = 8'ha4;
   localparam logic [7:0] RX_MASK_SET_OFS    = 8'ha8;
   localparam logic [7:0] RX_MASK_CLR_OFS    = 8'hac;
   localparam logic [7:0] INIT_BW_OFS        = 8'hb0;
   localparam logic [7:0] INIT_CH_HI_OFS     = 8'hb4;
   localparam logic [7:0] INIT_CH_LO_OFS     = 8'hb8;
   localparam logic [7:0] FAIRNESS_OFS       = 8'hdc;
   localparam logic [7:0] LINK_CTRL_SET_OFS  = 8'he0;
   localparam logic [7:0] LINK_CTRL_CLR_OFS  = 8'he4;
   localparam logic [7:0] STATUS_OFS         = 8'hf8;
   // ==========================================================
   // widths
   localparam int TX_CHANNELS = 8;
   localparam int RX_CHANNELS = 4;
   localparam int BW_WIDTH    = 13;
   localparam int PRI_WIDTH   = 8;
   // ==========================================================
   // link control field positions
   localparam int EXT_ROLLOVER_BIT   = 22;
   localparam int CYCLE_MASTER_BIT   = 21;
   localparam int OFFSET_ENABLE_BIT  = 20;
   localparam int PHY_PKT_BIT        = 10;
   localparam int SELF_ID_BIT        = 9;
   localparam int SYNC_LOCK_BIT      = 6;
   localparam logic [31:0] LINK_CTRL_WRITABLE = 32'h0070_0640;
   // ==========================================================
   // reset values
   localparam logic [12:0] INIT_BW_RESET    = 13'h1333;
   localparam logic [31:0] INIT_CH_RESET    = 32'hffff_ffff;
   localparam logic [7:0]  PRI_REQ_RESET    = 8'h00;
   // ==========================================================
   // cycle timer
   localparam logic [11:0] OFFSET_LAST      = 12'hbff;
endpackage

// >>> rtl/link_regs.sv
// host-visible register slice of a serial-bus link controller
`timescale 1ns/1ps
// How it works
// - transmit mask bits set by ones at set address, cleared at clear address.
// - mask reads at set or clear address return the mask unchanged.
// - a finished input descriptor with interrupt bits pulses its channel flag.
// - receive flag sets on rising edge of channel interrupt or software set.
// - receive flag clears only by writing one at clear address.
// - receive event read at clear address returns events AND mask.
// - four receive flags in bits 3..0; upper bits read zero.
// - receive mask bits set/cleared through set/clear address pair.
// - bandwidth field resets to 1333h on chip reset, not bus reset; read/write.
// - bandwidth field copied to bandwidth CSR on global, fundamental, function or bus reset, not power-on.
// - channels high resets all ones; copied to its CSR on resets.
// - channels low resets all ones; copied to its CSR on resets.
// - eight-bit priority request limit, default zero, upper bits zero.
// - external rollover select picks external input or 3072-count rollover.
// - cycle master sends cycle start per rollover while the count enable bit is set, else follows received ones.
// - overlong cycle event clears cycle master and blocks setting it.
// - offset counts only while the count enable bit is set.
// - phy packet accept bit, gated by async receive context enable.
// - self-id accept bit; software loads buffer pointer first.
// - sync lock forces tag-one sync filter bit on in all contexts.
// - sync lock clears only on fundamental, global or power-on reset.
// - link control reserved bits read zero; set/clear address pair.
// - eight transmit flags in bits 7..0 enabled by transmit mask.
module link_regs
   import link_regs_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   global_reset_input_i,
   input  wire logic                   host_link_fundamental_reset_i,
   input  wire logic                   function_reset_input_i,
   input  wire logic                   bus_reset_i,
   input  wire logic                   power_on_reset_i,
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   input  wire logic                   we_i,
   input  wire logic [7:0]             adr_i,
   input  wire logic [3:0]             sel_i,
   input  wire logic [31:0]            dat_i,
   output logic      [31:0]            dat_o,
   output logic                        ack_o,
   output logic                        err_o,
   input  wire logic [TX_CHANNELS-1:0] tx_channel_flag_i,
   input  wire logic [RX_CHANNELS-1:0] rx_context_irq_i,
   input  wire logic                   overlong_cycle_event_i,
   input  wire logic                   external_cycle_input_i,
   input  wire logic                   tick_24m_i,
   input  wire logic                   cycle_start_received_i,
   input  wire logic                   async_receive_context_i,
   output logic                        iso_transmit_summary_irq_o,
   output logic                        iso_receive_summary_irq_o,
   output logic      [12:0]            bandwidth_available_o,
   output logic      [31:0]            channels_available_hi_o,
   output logic      [31:0]            channels_available_lo_o,
   output logic      [7:0]             pri_req_limit_o,
   output logic      [11:0]            cycle_offset_o,
   output logic                        cycle_start_send_o,
   output logic                        accept_phy_packets_o,
   output logic                        accept_self_id_packets_o,
   output logic                        tag_one_sync_filter_force_o
);
   // ==========================================================
   // synchronisers for outside pins and reset requests
   logic [6:0] sync1_r;
   logic [6:0] sync2_r;
   logic       ext_cycle_prev_r;
   logic       tick_prev_r;
   logic [RX_CHANNELS-1:0] rx_irq_s1_r;
   logic [RX_CHANNELS-1:0] rx_irq_s2_r;
   logic [RX_CHANNELS-1:0] rx_irq_prev_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_r          <= '0;
         sync2_r          <= '0;
         ext_cycle_prev_r <= 1'b0;
         tick_prev_r      <= 1'b0;
         rx_irq_s1_r      <= '0;
         rx_irq_s2_r      <= '0;
         rx_irq_prev_r    <= '0;
      end
      else
      begin
         sync1_r <= {tick_24m_i, external_cycle_input_i, power_on_reset_i, bus_reset_i,
                     function_reset_input_i, host_link_fundamental_reset_i,
                     global_reset_input_i};
         sync2_r          <= sync1_r;
         ext_cycle_prev_r <= sync2_r[5];
         tick_prev_r      <= sync2_r[6];
         rx_irq_s1_r      <= rx_context_irq_i;
         rx_irq_s2_r      <= rx_irq_s1_r;
         rx_irq_prev_r    <= rx_irq_s2_r;
      end
   end

   logic global_reset_input;
   logic host_link_fundamental_reset;
   logic function_reset_input;
   logic bus_rst;
   logic por;
   logic ext_tick;
   logic clk24_tick;
   logic csr_load;
   assign global_reset_input       = sync2_r[0];
   assign host_link_fundamental_reset      = sync2_r[1];
   assign function_reset_input       = sync2_r[2];
   assign bus_rst    = sync2_r[3];
   assign por        = sync2_r[4];
   assign ext_tick   = sync2_r[5] & ~ext_cycle_prev_r;
   assign clk24_tick = sync2_r[6] & ~tick_prev_r;
   assign csr_load   = global_reset_input | host_link_fundamental_reset | function_reset_input | bus_rst;

   // ==========================================================
   // wishbone slave decode
   logic req;
   logic wr;
   logic hit;
   logic [31:0] wmask;
   assign req = cyc_i & stb_i & ~ack_o & ~err_o;
   assign wr  = req & we_i & hit;
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   logic [31:0] wbits;
   assign wbits = dat_i & wmask;

   always_comb
   begin
      case (adr_i)
         TX_MASK_SET_OFS, TX_MASK_CLR_OFS, RX_EVENT_SET_OFS, RX_EVENT_CLR_OFS,
         RX_MASK_SET_OFS, RX_MASK_CLR_OFS, INIT_BW_OFS, INIT_CH_HI_OFS,
         INIT_CH_LO_OFS, FAIRNESS_OFS, LINK_CTRL_SET_OFS, LINK_CTRL_CLR_OFS,
         STATUS_OFS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // ==========================================================
   // interrupt masks and receive events
   logic [TX_CHANNELS-1:0] tx_mask_r;
   logic [RX_CHANNELS-1:0] rx_mask_r;
   logic [RX_CHANNELS-1:0] rx_event_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tx_mask_r <= '0;
      else if (wr && adr_i == TX_MASK_SET_OFS)
         tx_mask_r <= tx_mask_r | wbits[TX_CHANNELS-1:0];
      else if (wr && adr_i == TX_MASK_CLR_OFS)
         tx_mask_r <= tx_mask_r & ~wbits[TX_CHANNELS-1:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rx_mask_r <= '0;
      else if (wr && adr_i == RX_MASK_SET_OFS)
         rx_mask_r <= rx_mask_r | wbits[RX_CHANNELS-1:0];
      else if (wr && adr_i == RX_MASK_CLR_OFS)
         rx_mask_r <= rx_mask_r & ~wbits[RX_CHANNELS-1:0];
   end

   genvar ch;
   generate
      for (ch = 0; ch < RX_CHANNELS; ch++)
      begin : g_rx_event
         logic set_ev;
         logic clr_ev;
         assign set_ev = (rx_irq_s2_r[ch] & ~rx_irq_prev_r[ch])
                       | (wr && adr_i == RX_EVENT_SET_OFS && wbits[ch]);
         assign clr_ev = wr && adr_i == RX_EVENT_CLR_OFS && wbits[ch];
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               rx_event_r[ch] <= 1'b0;
            else if (set_ev)
               rx_event_r[ch] <= 1'b1;
            else if (clr_ev)
               rx_event_r[ch] <= 1'b0;
         end
      end
   endgenerate

   assign iso_receive_summary_irq_o  = |(rx_event_r & rx_mask_r);
   assign iso_transmit_summary_irq_o = |(tx_channel_flag_i & tx_mask_r);

   // ==========================================================
   // initial bus-management values and fairness
   logic [12:0] init_bw_r;
   logic [31:0] init_ch_hi_r;
   logic [31:0] init_ch_lo_r;
   logic [7:0]  pri_req_r;
   logic        chip_rst;
   assign chip_rst = rst_i | global_reset_input;

   always_ff @(posedge clk_i)
   begin
      if (chip_rst)
      begin
         init_bw_r    <= INIT_BW_RESET;
         init_ch_hi_r <= INIT_CH_RESET;
         init_ch_lo_r <= INIT_CH_RESET;
         pri_req_r    <= PRI_REQ_RESET;
      end
      else if (wr)
      begin
         case (adr_i)
            INIT_BW_OFS:
               init_bw_r <= (init_bw_r & ~wmask[12:0]) | wbits[12:0];
            INIT_CH_HI_OFS:
               init_ch_hi_r <= (init_ch_hi_r & ~wmask) | wbits;
            INIT_CH_LO_OFS:
               init_ch_lo_r <= (init_ch_lo_r & ~wmask) | wbits;
            FAIRNESS_OFS:
               pri_req_r <= (pri_req_r & ~wmask[7:0]) | wbits[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bandwidth_available_o   <= INIT_BW_RESET;
         channels_available_hi_o <= INIT_CH_RESET;
         channels_available_lo_o <= INIT_CH_RESET;
      end
      else if (csr_load)
      begin
         bandwidth_available_o   <= init_bw_r;
         channels_available_hi_o <= init_ch_hi_r;
         channels_available_lo_o <= init_ch_lo_r;
      end
   end
   assign pri_req_limit_o = pri_req_r;

   // ==========================================================
   // link control
   logic [31:0] link_ctrl_r;
   logic        lock_r;
   logic [31:0] lc_set;
   logic [31:0] lc_clr;
   assign lc_set = (wr && adr_i == LINK_CTRL_SET_OFS) ? (wbits & LINK_CTRL_WRITABLE) : '0;
   assign lc_clr = (wr && adr_i == LINK_CTRL_CLR_OFS) ? (wbits & LINK_CTRL_WRITABLE) : '0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         link_ctrl_r <= '0;
      else
      begin
         link_ctrl_r <= ((link_ctrl_r | lc_set) & ~lc_clr) & LINK_CTRL_WRITABLE;
         if (overlong_cycle_event_i)
            link_ctrl_r[CYCLE_MASTER_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || host_link_fundamental_reset || global_reset_input || por)
         lock_r <= 1'b0;
      else if (lc_set[SYNC_LOCK_BIT])
         lock_r <= 1'b1;
   end

   logic [31:0] link_view;
   always_comb
   begin
      link_view = link_ctrl_r;
      link_view[SYNC_LOCK_BIT] = lock_r;
   end

   assign accept_phy_packets_o =
      link_ctrl_r[PHY_PKT_BIT] & async_receive_context_i;
   assign accept_self_id_packets_o    = link_ctrl_r[SELF_ID_BIT];
   assign tag_one_sync_filter_force_o = lock_r;

   // ==========================================================
   // cycle offset timer
   logic [11:0] offset_r;
   logic        rollover;
   always_comb
   begin
      if (link_ctrl_r[EXT_ROLLOVER_BIT])
         rollover = ext_tick;
      else
         rollover = clk24_tick && offset_r == OFFSET_LAST;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         offset_r <= '0;
      else if (!link_ctrl_r[CYCLE_MASTER_BIT] && cycle_start_received_i)
         offset_r <= '0;
      else if (link_ctrl_r[OFFSET_ENABLE_BIT])
      begin
         if (rollover)
            offset_r <= '0;
         else if (clk24_tick)
            offset_r <= offset_r + 12'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cycle_start_send_o <= 1'b0;
      else
         cycle_start_send_o <= link_ctrl_r[CYCLE_MASTER_BIT]
                             & link_ctrl_r[OFFSET_ENABLE_BIT] & rollover;
   end
   assign cycle_offset_o = offset_r;

   // ==========================================================
   // read data and answer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= '0;
      end
      else
      begin
         ack_o <= req & hit;
         err_o <= req & ~hit;
         dat_o <= '0;
         if (req && hit && !we_i)
         begin
            case (adr_i)
               TX_MASK_SET_OFS, TX_MASK_CLR_OFS:
                  dat_o <= {24'h0, tx_mask_r};
               RX_EVENT_SET_OFS:
                  dat_o <= {28'h0, rx_event_r};
               RX_EVENT_CLR_OFS:
                  dat_o <= {28'h0, rx_event_r & rx_mask_r};
               RX_MASK_SET_OFS, RX_MASK_CLR_OFS:
                  dat_o <= {28'h0, rx_mask_r};
               INIT_BW_OFS:       dat_o <= {19'h0, init_bw_r};
               INIT_CH_HI_OFS:    dat_o <= init_ch_hi_r;
               INIT_CH_LO_OFS:    dat_o <= init_ch_lo_r;
               FAIRNESS_OFS:      dat_o <= {24'h0, pri_req_r};
               LINK_CTRL_SET_OFS, LINK_CTRL_CLR_OFS:
                  dat_o <= link_view;
               STATUS_OFS:        dat_o <= {20'h0, offset_r};
               default:           dat_o <= '0;
            endcase
         end
      end
   end
endmodule

// >>> dv/link_regs_monitor.sv
// port-level assertion checker for the link register slice
`timescale 1ns/1ps
module link_regs_monitor
   import link_regs_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        global_reset_input_i,
   input wire logic        host_link_fundamental_reset_i,
   input wire logic        function_reset_input_i,
   input wire logic        bus_reset_i,
   input wire logic        power_on_reset_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic        overlong_cycle_event_i,
   input wire logic        async_receive_context_i,
   input wire logic        iso_receive_summary_irq_o,
   input wire logic [12:0] bandwidth_available_o,
   input wire logic [11:0] cycle_offset_o,
   input wire logic        cycle_start_send_o,
   input wire logic        accept_phy_packets_o,
   input wire logic        tag_one_sync_filter_force_o
);
   // ==========================================================
   // cycles since the last reset request
   logic [3:0] quiet_r;
   logic [3:0] lock_quiet_r;
   always_ff @(posedge clk_i)
   begin
      if (rst_i || global_reset_input_i || host_link_fundamental_reset_i || power_on_reset_i)
         lock_quiet_r <= 4'h0;
      else if (lock_quiet_r != 4'hf)
         lock_quiet_r <= lock_quiet_r + 4'h1;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || global_reset_input_i || host_link_fundamental_reset_i || power_on_reset_i
          || function_reset_input_i || bus_reset_i)
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hf)
         quiet_r <= quiet_r + 4'h1;
   end
   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   ack_cause_a: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
      else $error("answer without request");
   req_answer_a: assert property ((cyc_i && stb_i && !ack_o && !err_o) |=> (ack_o ^ err_o))
      else $error("request not answered next cycle");
   dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
   phy_gate_a: assert property (accept_phy_packets_o |-> async_receive_context_i)
      else $error("phy packets accepted with context off");
   offset_range_a: assert property (cycle_offset_o <= OFFSET_LAST)
      else $error("cycle offset beyond rollover");
   master_block_a: assert property (overlong_cycle_event_i [*4] |-> !cycle_start_send_o)
      else $error("cycle start sent during overlong cycle");
   rx_hold_a: assert property ($fell(iso_receive_summary_irq_o) |-> quiet_r < 4'hc
      || $past(we_i && (adr_i == RX_EVENT_CLR_OFS || adr_i == RX_MASK_CLR_OFS)))
      else $error("receive summary dropped without clear write");
   lock_hold_a: assert property ($fell(tag_one_sync_filter_force_o) |-> lock_quiet_r < 4'hc)
      else $error("sync lock cleared without reset");
   bw_hold_a: assert property ($changed(bandwidth_available_o) |-> quiet_r < 4'hc)
      else $error("bandwidth copy changed without reset");
   cover property (err_o);
   cover property (ack_o && we_i);
   cover property (iso_receive_summary_irq_o);
   cover property ($fell(tag_one_sync_filter_force_o));
endmodule
bind link_regs link_regs_monitor mon_u (.*);

// >>> dv/link_regs_tb_top.sv
// self-checking bench for the link register slice
`timescale 1ns/1ps
module link_regs_tb_top;
   import link_regs_pkg::*;
   logic                   clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   wire                    global_reset_input_i, host_link_fundamental_reset_i;
   wire                    function_reset_input_i, bus_reset_i, power_on_reset_i;
   logic                   overlong_cycle_event_i = 1'b0;
   logic [4:0]             rst_req = 5'h00;
   logic                   external_cycle_input_i = 1'b0, tick_24m_i = 1'b0;
   logic                   cycle_start_received_i = 1'b0, async_receive_context_i = 1'b0;
   logic [7:0]             adr_i = 8'h00;
   logic [3:0]             sel_i = 4'hf;
   logic [31:0]            dat_i = 32'h0, dat_o, rd;
   logic                   ack_o, err_o, last_err, cycle_start_send_o;
   logic [TX_CHANNELS-1:0] tx_channel_flag_i = 8'h00;
   logic [RX_CHANNELS-1:0] rx_context_irq_i = 4'h0;
   logic                   iso_transmit_summary_irq_o, iso_receive_summary_irq_o;
   logic                   accept_phy_packets_o, accept_self_id_packets_o;
   logic                   tag_one_sync_filter_force_o;
   logic [12:0]            bandwidth_available_o;
   logic [31:0]            channels_available_hi_o, channels_available_lo_o;
   logic [7:0]             pri_req_limit_o;
   logic [11:0]            cycle_offset_o, held;
   int                     err_count = 0, n_compared = 0, n_starts = 0;

   link_regs dut_u (.*);
   // reset requests: bus, function, fundamental, global, power-on
   assign {power_on_reset_i, global_reset_input_i, host_link_fundamental_reset_i,
           function_reset_input_i, bus_reset_i} = rst_req;

   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) tick_24m_i <= ~tick_24m_i;
   always @(posedge clk_i) if (cycle_start_send_o === 1'b1) n_starts++;

   // ==========================================================
   // tasks
   task automatic final_report;
      if (err_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do
         @(posedge clk_i);
      while (ack_o !== 1'b1 && err_o !== 1'b1);
      rd = dat_o;
      last_err = err_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic pulse(input logic [4:0] m);
      rst_req <= m;
      repeat (4) @(posedge clk_i);
      rst_req <= 5'h00;
      repeat (10) @(posedge clk_i);
   endtask

   initial
   begin
      repeat (8000) @(posedge clk_i);
      err_count++;
      final_report;
   end

   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // ==========================================================
      // reset values and unmapped access
      rdchk(INIT_BW_OFS, 32'h0000_1333);
      rdchk(INIT_CH_HI_OFS, 32'hffff_ffff);
      rdchk(INIT_CH_LO_OFS, 32'hffff_ffff);
      rdchk(FAIRNESS_OFS, 32'h0);
      rdchk(LINK_CTRL_SET_OFS, 32'h0);
      check(bandwidth_available_o, 32'h1333);
      rdchk(8'h00, 32'h0);
      check(last_err, 32'h1);
      // ==========================================================
      // transmit mask
      wb(1'b1, TX_MASK_SET_OFS, 32'h0000_00a5);
      rdchk(TX_MASK_CLR_OFS, 32'h0000_00a5);
      wb(1'b1, TX_MASK_CLR_OFS, 32'h0000_0021);
      rdchk(TX_MASK_SET_OFS, 32'h0000_0084);
      tx_channel_flag_i <= 8'h04;
      @(posedge clk_i);
      check(iso_transmit_summary_irq_o, 32'h1);
      tx_channel_flag_i <= 8'h02;
      @(posedge clk_i);
      check(iso_transmit_summary_irq_o, 32'h0);
      // ==========================================================
      // receive events and mask
      wb(1'b1, RX_MASK_SET_OFS, 32'h5);
      wb(1'b1, RX_EVENT_SET_OFS, 32'hffff_ffff);
      rdchk(RX_EVENT_SET_OFS, 32'hf);
      rdchk(RX_EVENT_CLR_OFS, 32'h5);
      rdchk(RX_MASK_CLR_OFS, 32'h5);
      check(iso_receive_summary_irq_o, 32'h1);
      wb(1'b1, RX_EVENT_CLR_OFS, 32'h1);
      rdchk(RX_EVENT_SET_OFS, 32'he);
      rx_context_irq_i <= 4'h1;
      repeat (6) @(posedge clk_i);
      rdchk(RX_EVENT_SET_OFS, 32'hf);
      rx_context_irq_i <= 4'h0;
      wb(1'b1, RX_MASK_CLR_OFS, 32'h5);
      check(iso_receive_summary_irq_o, 32'h0);
      wb(1'b1, RX_EVENT_CLR_OFS, 32'hf);
      rdchk(RX_EVENT_SET_OFS, 32'h0);
      // ==========================================================
      // link control
      async_receive_context_i <= 1'b1;
      wb(1'b1, LINK_CTRL_SET_OFS, 32'hffff_ffff);
      rdchk(LINK_CTRL_CLR_OFS, 32'h0070_0640);
      check(accept_phy_packets_o, 32'h1);
      check(accept_self_id_packets_o, 32'h1);
      check(tag_one_sync_filter_force_o, 32'h1);
      repeat (20) @(posedge clk_i);
      check(cycle_offset_o != 12'h000, 32'h1);
      wb(1'b1, LINK_CTRL_CLR_OFS, 32'hffff_ffff);
      rdchk(LINK_CTRL_SET_OFS, 32'h0000_0040);
      check(accept_phy_packets_o, 32'h0);
      held = cycle_offset_o;
      repeat (10) @(posedge clk_i);
      check(cycle_offset_o, held);
      wb(1'b1, LINK_CTRL_SET_OFS, 32'h0020_0000);
      overlong_cycle_event_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rdchk(LINK_CTRL_SET_OFS, 32'h0000_0040);
      wb(1'b1, LINK_CTRL_SET_OFS, 32'h0020_0000);
      rdchk(LINK_CTRL_SET_OFS, 32'h0000_0040);
      overlong_cycle_event_i <= 1'b0;
      wb(1'b1, LINK_CTRL_SET_OFS, 32'h0070_0000);
      external_cycle_input_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      check(n_starts, 32'h1);
      check(cycle_offset_o < 12'h004, 32'h1);
      wb(1'b1, LINK_CTRL_CLR_OFS, 32'h0040_0000);
      repeat (6200) @(posedge clk_i);
      check(n_starts, 32'h2);
      check(cycle_offset_o < 12'h040, 32'h1);
      wb(1'b1, LINK_CTRL_CLR_OFS, 32'h0020_0000);
      cycle_start_received_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      cycle_start_received_i <= 1'b0;
      check(cycle_offset_o, 32'h0);
      // ==========================================================
      // initial values and reset copies
      wb(1'b1, INIT_BW_OFS, 32'hffff_ffff);
      rdchk(INIT_BW_OFS, 32'h0000_1fff);
      wb(1'b1, FAIRNESS_OFS, 32'h0000_01ff);
      rdchk(FAIRNESS_OFS, 32'h0000_00ff);
      check(pri_req_limit_o, 32'hff);
      wb(1'b1, INIT_CH_LO_OFS, 32'h0000_c3a5);
      pulse(5'h01);
      check(bandwidth_available_o, 32'h1fff);
      check(channels_available_lo_o, 32'h0000_c3a5);
      check(channels_available_hi_o, 32'hffff_ffff);
      rdchk(INIT_BW_OFS, 32'h0000_1fff);
      check(tag_one_sync_filter_force_o, 32'h1);
      wb(1'b1, INIT_CH_HI_OFS, 32'h1234_5678);
      pulse(5'h02);
      check(channels_available_hi_o, 32'h1234_5678);
      check(tag_one_sync_filter_force_o, 32'h1);
      pulse(5'h04);
      check(tag_one_sync_filter_force_o, 32'h0);
      wb(1'b1, LINK_CTRL_SET_OFS, 32'h0000_0040);
      check(tag_one_sync_filter_force_o, 32'h1);
      pulse(5'h10);
      check(tag_one_sync_filter_force_o, 32'h0);
      pulse(5'h08);
      check(bandwidth_available_o, 32'h1333);
      rdchk(INIT_BW_OFS, 32'h0000_1333);
      rdchk(INIT_CH_LO_OFS, 32'hffff_ffff);
      final_report;
   end
endmodule
